// ==== bench/adc_conversion_serial_readout_bench.sv ====
// self-checking bench for the conversion-start and serial readout block
// assumes the host model drives all pins; sample_data comes from the bench
`timescale 1ns/1ps

module adc_conversion_serial_readout_bench;
  logic                     core_clk;
  logic                     rst;
  logic                     conversion_start;
  logic                     serial_in_mode_select;
  logic                     serial_clk;
  adccsr_pkg::adccsr_word_t sample_data;
  logic                     serial_out;
  logic                     serial_out_oe_n;
  logic                     conv_busy;
  logic                     sdo_line;
  logic                     b;
  int                       n_errors = 0;
  int                       n_tests = 0;

  assign sdo_line = serial_out_oe_n ? 1'b1 : serial_out;

  adccsr_top u_dut (
    .core_clk              (core_clk),
    .rst                   (rst),
    .conversion_start      (conversion_start),
    .serial_in_mode_select (serial_in_mode_select),
    .serial_clk            (serial_clk),
    .sample_data           (sample_data),
    .serial_out            (serial_out),
    .serial_out_oe_n       (serial_out_oe_n),
    .conv_busy             (conv_busy)
  );

  adccsr_host u_host (
    .core_clk              (core_clk),
    .conversion_start      (conversion_start),
    .serial_in_mode_select (serial_in_mode_select),
    .serial_clk            (serial_clk),
    .sdo_line              (sdo_line)
  );

  task automatic chk(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("Error at %0t ns: %s", $time, msg);
    end
  endtask

  // busy must rise soon after the start and last the fixed conversion span;
  // skip counts the busy cycles the caller has already spent
  task automatic wait_conv(input int skip);
    int n;
    n = 0;
    while (conv_busy !== 1'b1 && n < 10) begin
      u_host.cyc(1);
      n++;
    end
    n = skip;
    while (conv_busy === 1'b1 && n < 60) begin
      u_host.cyc(1);
      n++;
    end
    chk(n >= 37 && n <= 39, "conversion span wrong");
    u_host.cyc(3);
  endtask

  // sdv holds the serial input level for each fall, most significant first
  task automatic read_word(input adccsr_pkg::adccsr_word_t exp,
                           input adccsr_pkg::adccsr_word_t sdv);
    for (int i = 17; i >= 0; i--) begin
      u_host.shift(b, sdv[i]);
      chk(b === exp[i], "result bit wrong");
    end
  endtask

  task automatic t_cs_read(input adccsr_pkg::adccsr_word_t w);
    sample_data = w;
    u_host.start_conv(1'b1);
    wait_conv(0);
    chk(serial_out_oe_n === 1'b1, "driving before selection");
    u_host.pins(1'b0, 1'b1);
    u_host.cyc(5);
    chk(serial_out_oe_n === 1'b0, "not enabled by start low");
    read_word(w, 18'h3_FFFF);
    u_host.cyc(6);
    chk(serial_out_oe_n === 1'b1, "not released after last bit");
  endtask

  task automatic t_cs_abort(input adccsr_pkg::adccsr_word_t w);
    sample_data = w;
    u_host.start_conv(1'b1);
    wait_conv(0);
    u_host.pins(1'b1, 1'b0);
    u_host.cyc(5);
    chk(serial_out_oe_n === 1'b0, "not enabled by input low");
    for (int i = 17; i >= 15; i--) begin
      u_host.shift(b, 1'b0);
      chk(b === w[i], "bit wrong");
    end
    u_host.pins(1'b1, 1'b1);
    u_host.cyc(5);
    chk(serial_out_oe_n === 1'b1, "not released on input rise");
    u_host.shift(b, 1'b1);
    u_host.shift(b, 1'b1);
    chk(serial_out_oe_n === 1'b1, "clock while unselected enabled output");
    u_host.pins(1'b1, 1'b0);
    u_host.cyc(5);
    u_host.shift(b, 1'b0);
    chk(b === w[14], "unselected clock moved the word");
  endtask

  // start dropped mid-conversion turns the busy indicator on
  task automatic t_busy_cs(input adccsr_pkg::adccsr_word_t w);
    sample_data = w;
    u_host.start_conv(1'b1);
    u_host.cyc(4);
    u_host.pins(1'b0, 1'b1);
    u_host.cyc(5);
    chk(conv_busy === 1'b1 && serial_out === 1'b0, "out not low while busy");
    wait_conv(9);
    u_host.shift(b, 1'b1);
    chk(b === 1'b1, "no completion bit");
    read_word(w, 18'h3_FFFF);
  endtask

  // w must have a low msb so the chain-input rise is visible, chain a high
  // msb so the first own-word fall brings no second rise
  task automatic t_daisy(input adccsr_pkg::adccsr_word_t w,
                         input adccsr_pkg::adccsr_word_t chain);
    sample_data = w;
    u_host.start_conv(1'b0);
    wait_conv(0);
    chk(serial_out === 1'b1, "no completion bit in chain");
    u_host.pins(1'b0, 1'b0);
    u_host.cyc(5);
    chk(serial_out_oe_n === 1'b0, "chain output not driven");
    u_host.shift(b, 1'b0);
    chk(b === 1'b1 && serial_out === w[17], "leading one not consumed");
    u_host.pins(1'b0, 1'b1);
    u_host.cyc(5);
    chk(serial_out_oe_n === 1'b0 && serial_out === 1'b1, "chain input rise");
    u_host.shift(b, 1'b1);
    chk(b === 1'b1, "chain busy bit lost");
    read_word(w, chain);
    for (int i = 17; i >= 15; i--) begin
      u_host.shift(b, 1'b0);
      chk(b === chain[i], "chain bit not forwarded");
    end
  endtask

  // reset in mid-conversion drops the conversion and returns to chip-select
  task automatic t_mid_reset();
    sample_data = 18'h3_0C96;
    u_host.start_conv(1'b0);
    u_host.cyc(10);
    chk(conv_busy === 1'b1, "no conversion before reset");
    rst = 1'b1;
    u_host.cyc(3);
    rst = 1'b0;
    u_host.cyc(1);
    chk(conv_busy === 1'b0 && serial_out === 1'b0, "conversion kept over reset");
    u_host.cyc(1);
    chk(serial_out_oe_n === 1'b1, "mode not back to chip-select");
  endtask

  task automatic tally_and_finish();
    $display("Checks: %0d, errors: %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // whole run is under 100 us; hang cut off at five times that
  initial begin
    #500000;
    n_errors++;
    $display("Error at %0t ns: watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    rst         = 1'b1;
    sample_data = 18'h0_0000;
    repeat (10) @(posedge core_clk);
    #1;
    rst = 1'b0;
    u_host.cyc(3);
    chk(serial_out_oe_n === 1'b1 && conv_busy === 1'b0, "reset state wrong");
    t_cs_read(18'h2_D3A5);
    t_cs_abort(18'h1_5555);
    t_busy_cs(18'h0_F00F);
    t_daisy(18'h1_A5C3, 18'h2_C35A);
    t_mid_reset();
    t_cs_read(18'h1_2A68);
    tally_and_finish();
  end
endmodule

// ==== bench/adccsr_host.sv ====
// host controller model: drives conversion start, mode/chain input and serial clock
// assumes core_clk from the bench; pins change 1 ns after a core_clk rising edge
`timescale 1ns/1ps

module adccsr_host (
  // clock
  input  wire logic core_clk,
  // pins to the device
  output logic      conversion_start,
  output logic      serial_in_mode_select,
  output logic      serial_clk,
  // line from the device, pulled up when released
  input  wire logic sdo_line
);
  realtime last_start = -1.0e6;

  // serial clock idles high so the first event of a frame is a falling edge
  initial begin
    conversion_start      = 1'b0;
    serial_in_mode_select = 1'b1;
    serial_clk            = 1'b1;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic pins(input logic st, input logic sd);
    conversion_start      = st;
    serial_in_mode_select = sd;
  endtask

  task automatic start_conv(input logic cs_mode);
    while ($realtime - last_start < 2000.0) cyc(1);
    conversion_start      = 1'b0;
    serial_in_mode_select = cs_mode;
    cyc(3);
    conversion_start = 1'b1;
    last_start       = $realtime;
    cyc(4); // mode held well past the synchronisers
  endtask

  // capture the bit shown since the previous fall, then make one fall
  task automatic shift(output logic b, input logic sd);
    b                     = sdo_line;
    serial_in_mode_select = sd;
    cyc(2);
    serial_clk = 1'b0;
    cyc(4);
    serial_clk = 1'b1;
    cyc(2);
  endtask
endmodule

// ==== rtl/adccsr_fifo.sv ====
// result fifo: flip-flop storage, valid and ready on both sides
// assumes a single clock and synchronous active-high reset
`timescale 1ns/1ps

module adccsr_fifo #(
  parameter int W = 18,
  parameter int D = 8
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst,
  // write side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // read side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int PW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);

  logic [W-1:0]  mem_q [D];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] wr_d;
  logic [PW-1:0] rd_q;
  logic [PW-1:0] rd_d;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          push;
  logic          pop;

  function automatic logic [PW-1:0] nxt(input logic [PW-1:0] p);
    nxt = (p == PW'(D - 1)) ? '0 : p + PW'(1);
  endfunction

  assign in_ready  = (cnt_q != CW'(D));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    wr_d  = push ? nxt(wr_q) : wr_q;
    rd_d  = pop ? nxt(rd_q) : rd_q;
    cnt_d = cnt_q + CW'(push) - CW'(pop);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
endmodule

// ==== rtl/adccsr_params.svh ====
// constants of the conversion-start and serial readout block
// assumes a 25 MHz core clock; included by the package and the top module
`ifndef ADCCSR_PARAMS_SVH
`define ADCCSR_PARAMS_SVH

`define ADCCSR_CLK_NS      40
`define ADCCSR_T_CONV_NS   1500
`define ADCCSR_T_CYC_NS    2000
`define ADCCSR_CONV_CYC    (`ADCCSR_T_CONV_NS / `ADCCSR_CLK_NS)
`define ADCCSR_RES         18
`define ADCCSR_CNT_W       5
`define ADCCSR_TMR_W       6
`define ADCCSR_FIFO_DEPTH  8
`define ADCCSR_SYN_CNV     2
`define ADCCSR_SYN_SDI     1
`define ADCCSR_SYN_SCLK    0

`endif

// ==== rtl/adccsr_pkg.sv ====
// types of the conversion-start and serial readout block
// assumes adccsr_params.svh on the include path
`include "adccsr_params.svh"

package adccsr_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CONV,
    ST_PUSH
  } adccsr_conv_state_t;
  typedef logic [`ADCCSR_RES-1:0] adccsr_word_t;
endpackage

// ==== rtl/adccsr_top.sv ====
// conversion-start and serial readout logic of a single-channel converter
// assumes pins are asynchronous to core_clk and serial_clk is slow (320 ns)
`timescale 1ns/1ps
`include "adccsr_params.svh"

module adccsr_top (
  // clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst,
  // pins from the host
  input  wire logic                conversion_start,
  input  wire logic                serial_in_mode_select,
  input  wire logic                serial_clk,
  // converter core result
  input  wire adccsr_pkg::adccsr_word_t sample_data,
  // pins to the host
  output logic                     serial_out,
  output logic                     serial_out_oe_n,
  output logic                     conv_busy
);
  localparam int CONV_CYC = `ADCCSR_CONV_CYC;
  localparam int RES      = `ADCCSR_RES;

  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] prev_q;
  logic       s_cnv;
  logic       s_sdi;
  logic       cnv_rise;
  logic       cnv_fall;
  logic       sdi_rise;
  logic       sdi_fall;
  logic       sclk_fall;

  adccsr_pkg::adccsr_conv_state_t st_q;
  adccsr_pkg::adccsr_conv_state_t st_d;
  logic [`ADCCSR_TMR_W-1:0]       tmr_q;
  logic [`ADCCSR_TMR_W-1:0]       tmr_d;
  adccsr_pkg::adccsr_word_t       smp_q;
  adccsr_pkg::adccsr_word_t       smp_d;
  adccsr_pkg::adccsr_word_t       sh_q;
  adccsr_pkg::adccsr_word_t       sh_d;
  logic [`ADCCSR_CNT_W-1:0]       cnt_q;
  logic [`ADCCSR_CNT_W-1:0]       cnt_d;
  logic mode_cs_q, mode_cs_d, busy_en_q, busy_en_d, loaded_q, loaded_d;
  logic hold_hi_q, hold_hi_d, en_q, en_d, out_q, out_d, oe_n_q, oe_n_d;
  logic busy_q, busy_d, sel, shift;
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_pop;
  adccsr_pkg::adccsr_word_t fifo_out_data;

  // two flops per pin, a third only for edge finding; these run through reset
  // so the edge finder agrees with the pins and no false edge follows release
  always_ff @(posedge core_clk) begin
    sync1_q <= {conversion_start, serial_in_mode_select, serial_clk};
    sync2_q <= sync1_q;
    prev_q  <= sync2_q;
  end

  assign s_cnv     = sync2_q[`ADCCSR_SYN_CNV];
  assign s_sdi     = sync2_q[`ADCCSR_SYN_SDI];
  assign cnv_rise  = s_cnv & ~prev_q[`ADCCSR_SYN_CNV];
  assign cnv_fall  = ~s_cnv & prev_q[`ADCCSR_SYN_CNV];
  assign sdi_rise  = s_sdi & ~prev_q[`ADCCSR_SYN_SDI];
  assign sdi_fall  = ~s_sdi & prev_q[`ADCCSR_SYN_SDI];
  assign sclk_fall = ~sync2_q[`ADCCSR_SYN_SCLK] & prev_q[`ADCCSR_SYN_SCLK];

  // a full fifo stalls completion, so results are never dropped
  assign fifo_in_valid = (st_q == adccsr_pkg::ST_PUSH);
  assign fifo_pop = ~loaded_q & fifo_out_valid & (st_q == adccsr_pkg::ST_IDLE) & ~cnv_rise;
  assign sel   = mode_cs_q ? (~s_cnv | ~s_sdi) : ~s_cnv;
  assign shift = sclk_fall & sel & loaded_q & (st_q == adccsr_pkg::ST_IDLE);

  adccsr_fifo #(
    .W (RES),
    .D (`ADCCSR_FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (smp_q),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );

  // conversion control; a start during the push wait is ignored
  always_comb begin
    st_d      = st_q;
    tmr_d     = tmr_q;
    smp_d     = smp_q;
    mode_cs_d = mode_cs_q;
    busy_en_d = busy_en_q;
    if (cnv_rise && st_q != adccsr_pkg::ST_PUSH) begin
      st_d      = adccsr_pkg::ST_CONV;
      tmr_d     = '0;
      smp_d     = sample_data;
      mode_cs_d = s_sdi;
    end else if (st_q == adccsr_pkg::ST_CONV) begin
      tmr_d = tmr_q + `ADCCSR_TMR_W'(1);
      if (tmr_q == `ADCCSR_TMR_W'(CONV_CYC - 1)) begin
        st_d = adccsr_pkg::ST_PUSH;
      end
    end else if (st_q == adccsr_pkg::ST_PUSH && fifo_in_ready) begin
      st_d      = adccsr_pkg::ST_IDLE;
      busy_en_d = ~s_sdi | ~s_cnv;
    end
  end

  // readout shifter and pin drive
  always_comb begin
    sh_d      = sh_q;
    cnt_d     = cnt_q;
    loaded_d  = loaded_q;
    hold_hi_d = hold_hi_q;
    en_d      = en_q;
    if (cnv_rise && st_q != adccsr_pkg::ST_PUSH) begin
      loaded_d  = 1'b0;
      hold_hi_d = 1'b0;
    end else if (fifo_pop) begin
      sh_d      = fifo_out_data;
      cnt_d     = '0;
      loaded_d  = 1'b1;
      hold_hi_d = busy_en_q;
    end else if (shift) begin
      if (hold_hi_q) begin
        hold_hi_d = 1'b0;
      end else if (!mode_cs_q || cnt_q != `ADCCSR_CNT_W'(RES)) begin
        sh_d = {sh_q[RES-2:0], ~mode_cs_q & s_sdi};
        if (cnt_q != `ADCCSR_CNT_W'(RES)) begin
          cnt_d = cnt_q + `ADCCSR_CNT_W'(1);
        end
      end
    end else if (!mode_cs_q && busy_en_q && sdi_rise && loaded_q && cnt_q == '0) begin
      hold_hi_d = 1'b1;
    end
    if (cnv_fall || sdi_fall) begin
      en_d = 1'b1;
    end
    if (cnv_rise || sdi_rise || (loaded_d && cnt_d == `ADCCSR_CNT_W'(RES))) begin
      en_d = 1'b0;
    end
    busy_d = (st_d != adccsr_pkg::ST_IDLE);
    out_d  = busy_d ? 1'b0 : (hold_hi_d | (loaded_d & sh_d[RES-1]));
    oe_n_d = mode_cs_d ? ~en_d : 1'b0;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q      <= adccsr_pkg::ST_IDLE;
      tmr_q     <= '0;
      smp_q     <= '0;
      mode_cs_q <= 1'b1;
      busy_en_q <= 1'b0;
      sh_q      <= '0;
      cnt_q     <= '0;
      loaded_q  <= 1'b0;
      hold_hi_q <= 1'b0;
      en_q      <= 1'b0;
      busy_q    <= 1'b0;
      out_q     <= 1'b0;
      oe_n_q    <= 1'b1;
    end else begin
      st_q      <= st_d;
      tmr_q     <= tmr_d;
      smp_q     <= smp_d;
      mode_cs_q <= mode_cs_d;
      busy_en_q <= busy_en_d;
      sh_q      <= sh_d;
      cnt_q     <= cnt_d;
      loaded_q  <= loaded_d;
      hold_hi_q <= hold_hi_d;
      en_q      <= en_d;
      busy_q    <= busy_d;
      out_q     <= out_d;
      oe_n_q    <= oe_n_d;
    end
  end

  assign serial_out      = out_q;
  assign serial_out_oe_n = oe_n_q;
  assign conv_busy       = busy_q;

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  AST_CNV_START: assert property (cnv_rise && st_q != adccsr_pkg::ST_PUSH |=>
    st_q == adccsr_pkg::ST_CONV && tmr_q == '0) else $error("start not taken");
  AST_MODE_DAISY: assert property (cnv_rise && !s_sdi && st_q != adccsr_pkg::ST_PUSH
    |=> !mode_cs_q) else $error("daisy mode not set");
  AST_MODE_CS: assert property (cnv_rise && s_sdi && st_q != adccsr_pkg::ST_PUSH
    |=> mode_cs_q) else $error("cs mode not set");
  AST_CS_ENABLE: assert property (mode_cs_q && (cnv_fall || sdi_fall) && !cnv_rise
    && !sdi_rise && !(loaded_q && cnt_q == `ADCCSR_CNT_W'(RES)) && !fifo_pop && !shift
    |=> !serial_out_oe_n) else $error("output not enabled");
  AST_BUSY_EN: assert property (st_q == adccsr_pkg::ST_PUSH && fifo_in_ready && !cnv_rise
    |=> busy_en_q == (!$past(s_sdi) || !$past(s_cnv))) else $error("busy enable wrong");
  AST_OUT_ON_FALL: assert property (st_q == adccsr_pkg::ST_IDLE && loaded_q
    && $past(loaded_q) && $past(st_q) == adccsr_pkg::ST_IDLE && $changed(serial_out)
    |-> $past(sclk_fall) || $past(sdi_rise)) else $error("output moved off edge");
  AST_IGNORE_UNSEL: assert property (sclk_fall && !sel && !cnv_rise && !fifo_pop
    |=> $stable(cnt_q) && $stable(sh_q)) else $error("shift while unselected");
  AST_CHAIN_IN: assert property (shift && !mode_cs_q && !hold_hi_q && !cnv_rise
    |=> sh_q[0] == $past(s_sdi)) else $error("chain bit not sampled");
  AST_CS_RELEASE: assert property (mode_cs_d && (cnv_rise || sdi_rise)
    |=> serial_out_oe_n) else $error("output not released");
  AST_DAISY_BUSY_HI: assert property (!mode_cs_q && busy_en_q && sdi_rise && loaded_q
    && cnt_q == '0 && !shift && !cnv_rise |=> serial_out) else $error("chain busy low");
  AST_MSB_FIRST: assert property (mode_cs_q && loaded_q && !hold_hi_q && cnt_q == '0
    && st_q == adccsr_pkg::ST_IDLE |-> serial_out == sh_q[RES-1]) else $error("msb wrong");
  AST_CONV_TIME: assert property (st_q == adccsr_pkg::ST_CONV && !cnv_rise
    && tmr_q == `ADCCSR_TMR_W'(CONV_CYC - 1) |=> st_q == adccsr_pkg::ST_PUSH)
    else $error("conversion too long");
  AST_WORD_LEN: assert property (shift && mode_cs_q && !hold_hi_q && !cnv_rise
    && cnt_q == `ADCCSR_CNT_W'(RES - 1) |=> cnt_q == `ADCCSR_CNT_W'(RES)
    && serial_out_oe_n) else $error("word length wrong");
  AST_FORWARD: assert property (shift && !mode_cs_q && !hold_hi_q && !cnv_rise
    && cnt_q == `ADCCSR_CNT_W'(RES) |=> serial_out == $past(sh_q[RES-2]))
    else $error("chain bit not forwarded");
  AST_BUSY_LOW: assert property (st_q != adccsr_pkg::ST_IDLE |-> !serial_out)
    else $error("output high while converting");

  COV_CS_WORD: cover property (shift && mode_cs_q && cnt_q == `ADCCSR_CNT_W'(RES - 1));
  COV_DAISY_FWD: cover property (shift && !mode_cs_q && cnt_q == `ADCCSR_CNT_W'(RES));
  COV_BUSY_HI: cover property (loaded_q && hold_hi_q && busy_en_q);
  COV_FIFO_FULL: cover property (st_q == adccsr_pkg::ST_PUSH && !fifo_in_ready);
endmodule
